/* design/rss_pkg.sv */
// Package with constants and carriers for the regulator sync and supervisor
package rss_pkg;
  localparam int unsigned CLK_HZ         = 25_000_000;
  // Nominal link clock that times the oscillator itself
  localparam int unsigned LINK_HZ        = 31_250_000;
  localparam int unsigned FCODE_W        = 3;
  localparam int unsigned PER_W          = 16;
  localparam logic [2:0]  FCODE_LOWEST   = 3'h0;
  localparam logic [2:0]  FCODE_500K     = 3'h1;
  localparam logic [2:0]  FCODE_RESET    = 3'h1;
  localparam logic [2:0]  MCODE_RESET    = 3'h0;
  localparam int unsigned SLAVE_PULSES   = 10;
  localparam int unsigned SLAVE_KEEP_KHZ = 275;
  localparam int unsigned SLAVE_KEEP_CYC = (CLK_HZ / 1000 + SLAVE_KEEP_KHZ - 1)
                                           / SLAVE_KEEP_KHZ;
  localparam int unsigned STRAP_SETTLE_NS  = 1000;
  localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * 25 + 999) / 1000;
  localparam int unsigned DELAY_RAMP_CYC   = 1000;

  typedef struct packed {
    logic       low_noise_operation;
    logic [1:0] threshold_sel;
  } rss_mode_s;

  typedef struct packed {
    logic [2:0] freq_code;
    logic [2:0] slope_code;
    rss_mode_s  mode;
    logic       forced_slave;
  } rss_strap_s;
endpackage : rss_pkg

/* design/rss_sync2.sv */
// Two-flop synchroniser for a single level
`timescale 1ns/10ps
module rss_sync2 (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : rss_sync2

/* design/rss_osc.sv */
// Link-domain oscillator that drives the shared sync line
`timescale 1ns/10ps
module rss_osc #(
  parameter int unsigned PER_W = 16
) (
  input  wire logic             link_clk_in,
  input  wire logic             link_rst_n_in,
  input  wire logic [PER_W-1:0] half_period_in,
  input  wire logic             run_in,
  output logic                  wave_out,
  output logic                  edge_tgl_out
);
  logic [PER_W-1:0] cnt_q;
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_n_in) begin
      cnt_q        <= '0;
      wave_out     <= 1'b0;
      edge_tgl_out <= 1'b0;
    end else if (!run_in) begin
      cnt_q    <= '0;
      wave_out <= 1'b0;
    end else if (cnt_q + 1'b1 >= half_period_in) begin
      cnt_q    <= '0;
      wave_out <= ~wave_out;
      if (!wave_out) edge_tgl_out <= ~edge_tgl_out;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : rss_osc

/* design/rss_top.sv */
// Strap capture, supervisor and master/slave sync control
//
// Summary of operation
// R01 - Sample frequency strap once, then float pin
// R02 - Decode mode strap; default gives 93 percent
// R03 - Hold reset low while output out of regulation
// R04 - Four supervisor thresholds from mode strap
// R05 - Delay ramp after regulation, then release reset
// R06 - Default master, drive line at strap frequency
// R07 - Slave switches 180 degrees from peer master
// R08 - Slave runs oscillator at lowest code
// R09 - Ten fast pulses enter slave mode
// R10 - Slow line: one slave pulse, back to master
// R11 - Line low at power-up latches slave mode
// R12 - Slope setting latched at power-up
// R13 - Followers of external reference switch in phase
// R14 - External source keeps range and pulse width
// R15 - External master within twenty percent
// R16 - All devices share the same strap code
// R17 - Code 500k needs pulses above 550 kHz
// R18 - Judge frequency by cycles between rising edges
// R19 - Lost regulation reasserts reset, restarts delay
// R20 - Thermal recovery restarts soft-start
`timescale 1ns/10ps
module rss_top #(
  parameter int unsigned DELAY_CYC = rss_pkg::DELAY_RAMP_CYC
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        link_clk_in,
  input  wire logic [rss_pkg::FCODE_W-1:0] freq_select_strap_in,
  input  wire logic [2:0]                  mode_threshold_strap_in,
  input  wire logic [3:0]                  in_regulation_in,
  input  wire logic                        thermal_shutdown_in,
  input  wire logic                        external_ref_in,
  input  wire logic                        shared_sync_line_in,
  output logic                             shared_sync_line_out,
  output logic                             shared_sync_line_oe_out,
  output logic                             strap_drive_oe_out,
  output logic                             soft_start_go_out,
  output logic                             reset_low_oe_out,
  output logic                             slave_mode_out,
  output logic                             in_phase_out,
  output logic [rss_pkg::FCODE_W-1:0]      osc_code_out,
  output logic [2:0]                       slope_code_out,
  output logic                             low_noise_operation_out,
  output logic [1:0]                       threshold_sel_out
);
  import rss_pkg::*;

  typedef enum logic [1:0] {
    ST_STRAP  = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE  = 2'b10,
    ST_RETURN = 2'b11
  } rss_state_e;

  rss_state_e state_q, state_d;
  rss_strap_s strap_q;
  logic [7:0] settle_q;
  logic       sync_s, sync_prev_q, ext_s, therm_s, therm_prev_q;
  logic [3:0] reg_s;
  logic [PER_W-1:0] per_q;
  logic [3:0] fast_cnt_q;
  logic [31:0] delay_q;
  logic       link_rst_n_q, run_tgl_s, tgl_prev_q;
  logic       link_rst_meta_q, slow_q, slow_link_s, wave_s, tgl_s;
  logic [FCODE_W-1:0] fs_s;
  logic [2:0] ms_s;
  logic       osc_wave, osc_tgl;
  logic [PER_W-1:0] half_per;

  // Pin inputs through two flops
  rss_sync2 u_sync_line (
    .clk_in  (clk_in),
    .rst_n_in(rst_n_in),
    .d_in    (shared_sync_line_in),
    .q_out   (sync_s)
  );
  rss_sync2 u_ext (
    .clk_in  (clk_in),
    .rst_n_in(rst_n_in),
    .d_in    (external_ref_in),
    .q_out   (ext_s)
  );
  rss_sync2 u_therm (
    .clk_in  (clk_in),
    .rst_n_in(rst_n_in),
    .d_in    (thermal_shutdown_in),
    .q_out   (therm_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_reg
      rss_sync2 u_reg (
        .clk_in  (clk_in),
        .rst_n_in(rst_n_in),
        .d_in    (in_regulation_in[gi]),
        .q_out   (reg_s[gi])
      );
    end
    // Straps are static pins but still arrive unclocked
    for (gi = 0; gi < 3; gi++) begin : g_strap
      rss_sync2 u_fsel (
        .clk_in  (clk_in),
        .rst_n_in(rst_n_in),
        .d_in    (freq_select_strap_in[gi]),
        .q_out   (fs_s[gi])
      );
      rss_sync2 u_mode (
        .clk_in  (clk_in),
        .rst_n_in(rst_n_in),
        .d_in    (mode_threshold_strap_in[gi]),
        .q_out   (ms_s[gi])
      );
    end
  endgenerate

  // Per-code nominal period in clk cycles and fast-entry limit
  function automatic logic [PER_W-1:0] code_period(input logic [2:0] c);
    code_period = PER_W'(CLK_HZ / (250_000 * (32'(c) + 1)));
  endfunction

  // Faster than max spread: period below 10/11 of nominal [R17]
  function automatic logic [PER_W-1:0] fast_limit(input logic [2:0] c);
    fast_limit = PER_W'((32'(code_period(c)) * 10) / 11);
  endfunction

  // Half period in link-clock cycles; own pulses must not look fast
  function automatic logic [PER_W-1:0] link_half(input logic [2:0] c);
    link_half = PER_W'(LINK_HZ / (250_000 * (32'(c) + 1)) / 2);
  endfunction

  wire [2:0] active_code = (state_q == ST_SLAVE || state_q == ST_RETURN ||
                            strap_q.forced_slave) ? FCODE_LOWEST
                                                  : strap_q.freq_code;
  wire       sync_rise   = sync_s & ~sync_prev_q;
  wire       strap_done  = (settle_q == 8'(STRAP_SETTLE_CYC));
  wire       fast_pulse  = sync_rise && (per_q < fast_limit(strap_q.freq_code));
  wire       slow_line   = (per_q >= PER_W'(SLAVE_KEEP_CYC));
  wire       in_reg      = reg_s[strap_q.mode.threshold_sel];     // [R04]
  wire       therm_rec   = therm_prev_q & ~therm_s;
  wire       own_pulse   = (tgl_s != tgl_prev_q);

  // Strap capture once after reset; thermal recovery re-runs soft-start
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      settle_q <= '0;
      strap_q  <= '{freq_code: FCODE_RESET, slope_code: FCODE_RESET,
                   mode: '{low_noise_operation: 1'b1,
                           threshold_sel: MCODE_RESET[1:0] + 2'h2},
                   forced_slave: 1'b0};
    end else if (!strap_done) begin
      settle_q <= settle_q + 8'h01;
      if (settle_q == 8'(STRAP_SETTLE_CYC - 1)) begin
        strap_q.freq_code  <= fs_s;                             // [R01]
        strap_q.slope_code <= fs_s;                             // [R12]
        strap_q.mode.low_noise_operation <= ~ms_s[2];           // [R02]
        strap_q.mode.threshold_sel <= ms_s[1:0] ^ 2'h2;
        strap_q.forced_slave <= ~sync_s;                        // [R11]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      soft_start_go_out  <= 1'b0;
      strap_drive_oe_out <= 1'b1;
      therm_prev_q       <= 1'b0;
    end else begin
      therm_prev_q       <= therm_s;
      strap_drive_oe_out <= !strap_done;                        // [R01]
      soft_start_go_out  <= strap_done && !therm_s && !therm_rec; // [R20]
    end
  end

  // Period counter between rising edges [R18]
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_prev_q <= 1'b0;
      per_q       <= '0;
      fast_cnt_q  <= '0;
      tgl_prev_q  <= 1'b0;
    end else begin
      sync_prev_q <= sync_s;
      tgl_prev_q  <= tgl_s;
      if (sync_rise) per_q <= '0;
      else if (per_q != '1) per_q <= per_q + 1'b1;
      if (state_q != ST_MASTER) fast_cnt_q <= '0;
      else if (fast_pulse) fast_cnt_q <= fast_cnt_q + 4'h1;       // [R09]
      else if (sync_rise) fast_cnt_q <= '0;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STRAP:  if (strap_done)
                   state_d = strap_q.forced_slave ? ST_SLAVE : ST_MASTER;
      ST_MASTER: if (fast_pulse && fast_cnt_q == 4'(SLAVE_PULSES - 1))
                   state_d = ST_SLAVE;                           // [R09]
      ST_SLAVE:  if (slow_line && !strap_q.forced_slave)
                   state_d = ST_RETURN;                          // [R10]
      ST_RETURN: if (sync_rise && !slow_line)
                   state_d = ST_SLAVE;
                 else if (own_pulse)
                   state_d = ST_MASTER;                          // [R10]
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) state_q <= ST_STRAP;
    else           state_q <= state_d;
  end

  // Supervisor with delay ramp
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      delay_q          <= '0;
      reset_low_oe_out <= 1'b1;
    end else if (!in_reg || !soft_start_go_out) begin
      delay_q          <= '0;                                    // [R19]
      reset_low_oe_out <= 1'b1;                                  // [R03]
    end else if (delay_q < DELAY_CYC) begin
      delay_q          <= delay_q + 32'h1;                       // [R05]
      reset_low_oe_out <= 1'b1;
    end else begin
      reset_low_oe_out <= 1'b0;                                  // [R05]
    end
  end

  // Outputs and phase relation
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      slave_mode_out          <= 1'b0;
      in_phase_out            <= 1'b0;
      osc_code_out            <= FCODE_RESET;
      slope_code_out          <= FCODE_RESET;
      low_noise_operation_out <= 1'b1;
      threshold_sel_out       <= 2'h2;
      shared_sync_line_out    <= 1'b0;
      shared_sync_line_oe_out <= 1'b0;
    end else begin
      // Still slave until the fallback pulse has gone out [R10]
      slave_mode_out          <= (state_q == ST_SLAVE ||
                                  state_q == ST_RETURN);
      // External ref: in phase; peer master: anti-phase [R13] [R07]
      in_phase_out            <= ext_s;
      osc_code_out            <= active_code;                     // [R08]
      slope_code_out          <= strap_q.slope_code;              // [R12]
      low_noise_operation_out <= strap_q.mode.low_noise_operation;
      threshold_sel_out       <= strap_q.mode.threshold_sel;
      // Master and fallback pulse drive the line [R06]
      // Both levels driven; a released line idles at its pull-up
      shared_sync_line_out    <= wave_s;
      shared_sync_line_oe_out <= (state_q == ST_MASTER ||
                                  state_q == ST_RETURN);
    end
  end

  // Rate select crosses as one registered bit; the strap code is
  // static whenever the oscillator runs, so it needs no handshake
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) slow_q <= 1'b0;
    else           slow_q <= (active_code == FCODE_LOWEST);    // [R08]
  end

  always_ff @(posedge link_clk_in) begin
    link_rst_meta_q <= rst_n_in;
    link_rst_n_q    <= link_rst_meta_q;
  end

  rss_sync2 u_slow (
    .clk_in  (link_clk_in),
    .rst_n_in(link_rst_n_q),
    .d_in    (slow_q),
    .q_out   (slow_link_s)
  );
  assign half_per = link_half(slow_link_s ? FCODE_LOWEST
                                          : strap_q.freq_code);
  rss_sync2 u_run (
    .clk_in  (link_clk_in),
    .rst_n_in(link_rst_n_q),
    .d_in    (~strap_drive_oe_out),
    .q_out   (run_tgl_s)
  );

  // Oscillator wave and edge toggle come back through two flops
  rss_sync2 u_wave (
    .clk_in  (clk_in),
    .rst_n_in(rst_n_in),
    .d_in    (osc_wave),
    .q_out   (wave_s)
  );
  rss_sync2 u_tgl (
    .clk_in  (clk_in),
    .rst_n_in(rst_n_in),
    .d_in    (osc_tgl),
    .q_out   (tgl_s)
  );
  rss_osc #(.PER_W(PER_W)) u_osc (
    .link_clk_in   (link_clk_in),
    .link_rst_n_in (link_rst_n_q),
    .half_period_in(half_per),
    .run_in        (run_tgl_s),
    .wave_out      (osc_wave),
    .edge_tgl_out  (osc_tgl)
  );
endmodule : rss_top

/* tb/rss_top_properties.sv */
// Port-level assertions for the sync and supervisor top
`timescale 1ns/10ps
module rss_top_properties
  import rss_pkg::*;
#(
  parameter int unsigned DELAY_CYC = 20
) (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [2:0] mode_threshold_strap_in,
  input wire logic [3:0] in_regulation_in,
  input wire logic       strap_drive_oe_out,
  input wire logic       soft_start_go_out,
  input wire logic       reset_low_oe_out,
  input wire logic       slave_mode_out,
  input wire logic       in_phase_out,
  input wire logic [2:0] osc_code_out,
  input wire logic [2:0] slope_code_out,
  input wire logic       low_noise_operation_out,
  input wire logic [1:0] threshold_sel_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0] ok_cnt_q;
  // Any dropout restarts the count, as the delay must
  always_ff @(posedge clk_in)
    if (!rst_n_in || !in_regulation_in[threshold_sel_out])
      ok_cnt_q <= '0;
    else if (ok_cnt_q != 16'hffff)
      ok_cnt_q <= ok_cnt_q + 16'h0001;
  chk_reset_held: assert property (
    !in_regulation_in[threshold_sel_out] [*5] |-> reset_low_oe_out)
    else $error("reset released out of regulation");
  chk_release_delay: assert property (
    $fell(reset_low_oe_out) |-> ok_cnt_q >= DELAY_CYC)
    else $error("reset released before delay");
  chk_strap_float: assert property (
    !strap_drive_oe_out |=> !strap_drive_oe_out)
    else $error("strap pin driven again");
  chk_start_order: assert property (
    soft_start_go_out |-> !strap_drive_oe_out)
    else $error("soft-start before strap capture");
  chk_start_after: assert property (
    $fell(strap_drive_oe_out) |-> ##[1:4] soft_start_go_out)
    else $error("soft-start missing after capture");
  chk_slope_fixed: assert property (
    !strap_drive_oe_out && !$past(strap_drive_oe_out)
    |-> $stable(slope_code_out)) else $error("slope code changed");
  chk_slave_code: assert property (
    slave_mode_out [*3] |-> osc_code_out == FCODE_LOWEST)
    else $error("slave not at lowest code");
  chk_master_code: assert property (
    (!slave_mode_out && !strap_drive_oe_out) [*4]
    |-> osc_code_out == slope_code_out) else $error("master code wrong");
  chk_thresh_decode: assert property (
    $fell(strap_drive_oe_out) |-> ##[0:2] threshold_sel_out ==
    (mode_threshold_strap_in[1:0] ^ 2'h2)) else $error("threshold wrong");
  chk_mode_decode: assert property (
    $fell(strap_drive_oe_out) |-> ##[0:2]
    low_noise_operation_out == !mode_threshold_strap_in[2])
    else $error("mode wrong");
  cov_slave: cover property ($rose(slave_mode_out));
  cov_release: cover property ($fell(reset_low_oe_out));
  cov_phase: cover property ($rose(in_phase_out));
endmodule : rss_top_properties

bind rss_top rss_top_properties #(.DELAY_CYC(DELAY_CYC)) u_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in),
  .mode_threshold_strap_in(mode_threshold_strap_in),
  .in_regulation_in(in_regulation_in),
  .strap_drive_oe_out(strap_drive_oe_out),
  .soft_start_go_out(soft_start_go_out),
  .reset_low_oe_out(reset_low_oe_out), .slave_mode_out(slave_mode_out),
  .in_phase_out(in_phase_out), .osc_code_out(osc_code_out),
  .slope_code_out(slope_code_out),
  .low_noise_operation_out(low_noise_operation_out),
  .threshold_sel_out(threshold_sel_out));

/* tb/rss_peer_model.sv */
// Peer clock master that drives or pins low the shared sync line
`timescale 1ns/10ps
module rss_peer_model #(
  parameter int unsigned PERIOD = 42 // 595 kHz: over 550k, in 20 %
) (
  input  wire logic clk_in,
  input  wire logic run_in,
  input  wire logic hold_low_in,
  output logic      oe_out,
  output logic      level_out,
  output int        edges_out
);
  int cnt_q = 0;
  initial edges_out = 0;
  always @(posedge clk_in) begin
    cnt_q <= (!run_in || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    if (run_in && cnt_q == 0)
      edges_out <= edges_out + 1;
  end
  // 21 cycles high: far over 100 ns, rate below 1.4 MHz
  assign level_out = run_in && !hold_low_in && cnt_q < PERIOD / 2;
  assign oe_out    = run_in || hold_low_in;
endmodule : rss_peer_model

/* tb/regulator_sync_and_supervisor_tb_top.sv */
// Bench: strap capture, supervisor delay, sync master and slave
`timescale 1ns/10ps
module regulator_sync_and_supervisor_tb_top;
  import rss_pkg::*;
  localparam int unsigned DLY = 20;
  typedef struct packed {logic [2:0] sel; logic [3:0] val;} rss_note_s;
  logic       clk_in = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic [2:0] fs = FCODE_500K; // Peer strapped alike
  logic [2:0] ms = 3'h0, osc, slope;
  logic [3:0] inreg = 4'h0, sel_bit;
  logic       therm = 1'b0, ext = 1'b0, p_run = 1'b0, p_low = 1'b0;
  logic       p_oe, p_lvl, line, d_out, d_oe, strap_oe, soft_go, rst_oe;
  logic       slave, in_ph, low_noise;
  logic [1:0] thr;
  int         p_edges, miscompares = 0, n_tests = 0;
  rss_note_s  notes[$], nt;
  always #20 clk_in = ~clk_in;
  initial #7 forever #16 link_clk = ~link_clk;
  // A released line rises to its pull-up
  assign line    = p_oe ? p_lvl : (d_oe ? d_out : 1'b1);
  assign sel_bit = 4'h1 << (ms[1:0] ^ 2'h2);
  rss_top #(.DELAY_CYC(DLY)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n), .link_clk_in(link_clk),
    .freq_select_strap_in(fs), .mode_threshold_strap_in(ms),
    .in_regulation_in(inreg), .thermal_shutdown_in(therm),
    .external_ref_in(ext), .shared_sync_line_in(line),
    .shared_sync_line_out(d_out), .shared_sync_line_oe_out(d_oe),
    .strap_drive_oe_out(strap_oe), .soft_start_go_out(soft_go),
    .reset_low_oe_out(rst_oe), .slave_mode_out(slave),
    .in_phase_out(in_ph), .osc_code_out(osc), .slope_code_out(slope),
    .low_noise_operation_out(low_noise), .threshold_sel_out(thr));
  rss_peer_model peer (.clk_in(clk_in), .run_in(p_run), .hold_low_in(p_low),
    .oe_out(p_oe), .level_out(p_lvl), .edges_out(p_edges));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task automatic note(input logic [2:0] sel, input logic [3:0] val);
    notes.push_back('{sel, val});
  endtask : note
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [3:0] observe(input logic [2:0] sel);
    case (sel)
      3'h0: return {3'h0, rst_oe};
      3'h1: return {3'h0, slave};
      3'h2: return {1'h0, osc};
      3'h3: return {1'h0, slope};
      3'h4: return {1'h0, low_noise, thr};
      3'h5: return {2'h0, soft_go, strap_oe};
      default: return {3'h0, in_ph};
    endcase
  endfunction : observe
  // Results settle by the falling edge
  always @(negedge clk_in)
    while (notes.size() != 0) begin
      nt = notes.pop_front();
      check(observe(nt.sel), nt.val);
    end
  task automatic power_up(input logic low);
    ms <= 3'($urandom);
    p_low <= low;
    rst_n <= 1'b0;
    tick(8);
    rst_n <= 1'b1;
    tick(40);
    p_low <= 1'b0;
    note(3'h5, 4'h2);
    note(3'h3, {1'h0, fs});
    note(3'h4, {1'h0, ~ms[2], ms[1:0] ^ 2'h2});
    note(3'h1, {3'h0, low});
    note(3'h2, {1'h0, low ? FCODE_LOWEST : fs});
    tick(1);
  endtask : power_up
  task automatic regul(input logic ok, input int n, input logic exp);
    inreg <= ok ? (4'($urandom) | sel_bit) : (4'($urandom) & ~sel_bit);
    tick(n);
    note(3'h0, {3'h0, exp});
  endtask : regul
  task automatic follow(input logic e);
    int base;
    base = p_edges;
    ext <= e;
    p_run <= 1'b1;
    while (p_edges < base + 9) tick(1);
    tick(3);
    note(3'h1, 4'h0);
    // First peer edge may land on our own high level; allow one spare
    while (p_edges < base + 12) tick(1);
    tick(8);
    note(3'h1, 4'h1);
    note(3'h2, {1'h0, FCODE_LOWEST});
    note(3'h6, {3'h0, e});
    tick(420);
    note(3'h1, 4'h1);
    p_run <= 1'b0;
    tick(400);
    note(3'h1, 4'h0);
    note(3'h2, {1'h0, fs});
  endtask : follow
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(86));
    power_up(1'b0);
    regul(1'b0, DLY + 10, 1'b1);
    regul(1'b1, DLY - 2, 1'b1);
    regul(1'b1, 10, 1'b0);
    regul(1'b0, 5, 1'b1);
    regul(1'b1, DLY - 2, 1'b1);
    regul(1'b1, 10, 1'b0);
    therm <= 1'b1;
    tick(6);
    note(3'h5, 4'h0);
    therm <= 1'b0;
    tick(40);
    note(3'h5, 4'h2);
    follow(1'b1);
    follow(1'b0);
    power_up(1'b1);
    tick(400);
    note(3'h1, 4'h1);
    note(3'h3, {1'h0, fs});
    tick(2);
    tally_and_finish();
  end
  // Run needs about 3200 cycles; allow six times that
  initial begin
    #(40 * 20000);
    miscompares++;
    tally_and_finish();
  end
endmodule : regulator_sync_and_supervisor_tb_top
